// File: hdl/fslc_top.sv
// Fan speed loop control: registers, loop, monitoring
`timescale 1ns/100ps
`include "fslc_defs.svh"
// Operation
// R01: Prescaler divides feedback by 1,2,4,8
// R02: Host keeps prescaled full speed 33-66 Hz
// R03: Update register sets interval while free-running
// R04: Only three low update bits decode
// R05: Update register resets to 0.25 Hz
// R06: Gain bit0 clear gives closed speed loop
// R07: Gain bit0 set drives voltage from setpoint
// R08: Open loop ignores tachometer input
// R09: Fan open loop forces thermal open
// R10: Driver off above 150, on below 140
// R11: Gain bit1 selects current-pulse feedback
// R12: Each current step makes one pulse
// R13: Count oscillator ticks, load on tach
// R14: Fail when count exceeds limit register
// R15: Full-speed flag in closed loop
// R16: Counter overflow ORed into fail bit
// R17: Mode bit7 enables resistance cancellation
// R18: Host uses cancellation at 1 Hz or slower
// R19: Mode bits 5-2 adjust ADC gain
// R20: Mode bits 6,1,0 have no function
// R21: Reference derived from 8415 Hz oscillator
// R22: Reference divided by setpoint gives target
// R23: Host avoids prescale one with current sense
// R24: Six-stage up/down counter sets drive
// R25: Full-scale divider below 127 reads 127
// R26: Gain bits 6:5 select 16,32,63 span
// R27: Fan open loop holds fail at one
// R28: Inputs synchronised, single edges detected
// R29: Period counter saturates, restarts on load
module fslc_top import fslc_pkg::*; #(
  parameter int OSC_DIV = `FSLC_OSC_CYC
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Register access
  input  wire fslc_req_type req,
  output logic [7:0]        rdata,
  output logic              rvalid,
  // Fan pins and sensors
  input  wire logic         tach_in,
  input  wire logic         cur_step_in,
  input  wire logic [7:0]   drv_temp,
  input  wire logic         run_stop,
  input  wire logic         therm_open_cfg,
  // Fan drive and status
  output logic [6:0]        fan_drive,
  output logic              fan_drv_en,
  output logic              fan_fail,
  output logic              full_speed,
  output logic              therm_open,
  output fslc_adc_type      adc_cfg
);
  fslc_state_type st_q;
  fslc_state_type st_d;

  logic       osc_tick;
  logic       ref_tick;
  logic       fb_tick;
  logic       tach_rise;
  logic       cur_rise;
  logic       fb_raw;
  logic       open_lp;
  logic [7:0] fullscale_eff;
  logic [3:0] pre_div;
  logic [6:0] span;
  logic [17:0] upd_lim;

  // Pins are asynchronous: two flops before any edge logic
  fslc_edge_sync u_tach_sync ( // R28
    .clk  (clk),
    .rst  (rst),
    .pin  (tach_in),
    .rise (tach_rise)
  );

  fslc_edge_sync u_cur_sync ( // R28
    .clk  (clk),
    .rst  (rst),
    .pin  (cur_step_in),
    .rise (cur_rise)
  );

  fslc_pulse_div #(.W(15)) u_osc_div (
    .clk       (clk),
    .rst       (rst),
    .in_pulse  (1'b1),
    .div       (15'(OSC_DIV)),
    .out_pulse (osc_tick)
  );

  fslc_pulse_div #(.W(8)) u_ref_div (
    .clk       (clk),
    .rst       (rst),
    .in_pulse  (osc_tick),
    .div       (fullscale_eff),
    .out_pulse (ref_tick)
  );

  fslc_pulse_div #(.W(4)) u_pre_div (
    .clk       (clk),
    .rst       (rst),
    .in_pulse  (fb_raw),
    .div       (pre_div),
    .out_pulse (fb_tick)
  );

  always_comb begin
    open_lp = st_q.loop_gain_cfg[`FSLC_GAIN_OPEN];
    // Small divisors would overspeed the reference
    fullscale_eff = (st_q.ref_fullscale_divider < `FSLC_FSCALE_MIN) ? `FSLC_FSCALE_MIN
                                                                    : st_q.ref_fullscale_divider; // R25
    pre_div = 4'h1 << st_q.tach_prescale_divisor[1:0]; // R01
    // Open loop cuts every feedback path
    fb_raw  = ~open_lp & (st_q.loop_gain_cfg[`FSLC_GAIN_CSENSE] ? cur_rise : tach_rise); // R08 R11 R12
    // Code 11 is undefined; treated as widest span
    case (st_q.loop_gain_cfg[6:5]) // R26
      2'b00:   span = 7'h10;
      2'b01:   span = 7'h20;
      default: span = 7'h3f;
    endcase
    upd_lim = `FSLC_UPD_SLOW >> st_q.loop_update_rate[2:0]; // R04
  end

  always_comb begin
    st_d        = st_q;
    st_d.rvalid = 1'b0;
    st_d.des    = 1'b0;
    // Register writes
    if (req.wr) begin
      if (req.cmd == `FSLC_WR_PRESC) begin
        st_d.tach_prescale_divisor = req.wdata;
      end else if (req.cmd == `FSLC_WR_PLIM) begin
        st_d.tach_period_limit = req.wdata;
      end else if (req.cmd == `FSLC_WR_RATE) begin
        st_d.loop_update_rate = req.wdata;
      end else if (req.cmd == `FSLC_WR_MODE) begin
        st_d.mode = req.wdata;
      end else if (req.cmd == `FSLC_WR_FSCALE) begin
        st_d.ref_fullscale_divider = req.wdata;
      end else if (req.cmd == `FSLC_WR_SETPOINT) begin
        st_d.speed_setpoint = req.wdata[6:0]; // R06 R07
      end else if (req.cmd == `FSLC_WR_GAIN) begin
        // Reserved top bit stays one; clearing it resets bits 6:5 to 00 and keeps bits 4:0
        st_d.loop_gain_cfg = req.wdata[7] ? req.wdata : {3'b100, req.wdata[4:0]};
      end
    end
    // Register reads, unknown codes read zero
    if (req.rd) begin
      st_d.rvalid = 1'b1;
      if (req.cmd == `FSLC_RD_PRESC) begin
        st_d.rdata = st_q.tach_prescale_divisor;
      end else if (req.cmd == `FSLC_RD_PLIM) begin
        st_d.rdata = st_q.tach_period_limit;
      end else if (req.cmd == `FSLC_RD_PCOUNT) begin
        st_d.rdata = st_q.tach_period_count;
      end else if (req.cmd == `FSLC_RD_RATE) begin
        st_d.rdata = st_q.loop_update_rate;
      end else if (req.cmd == `FSLC_RD_MODE) begin
        st_d.rdata = {st_q.mode[7], 1'b0, st_q.mode[5:2], 2'b00}; // R20
      end else if (req.cmd == `FSLC_RD_FSCALE) begin
        st_d.rdata = st_q.ref_fullscale_divider;
      end else if (req.cmd == `FSLC_RD_SETPOINT) begin
        st_d.rdata = {1'b0, st_q.speed_setpoint};
      end else if (req.cmd == `FSLC_RD_GAIN) begin
        st_d.rdata = st_q.loop_gain_cfg;
      end else if (req.cmd == `FSLC_RD_STATUS) begin
        st_d.rdata = {6'h00, st_q.full_speed, st_q.fan_fail};
      end else begin
        st_d.rdata = 8'h00;
      end
    end
    // Loop update interval, held while stopped
    if (!run_stop && osc_tick) begin // R03
      if (st_q.upd_cnt + 18'd1 >= upd_lim) begin
        st_d.upd_cnt = '0;
        st_d.target  = st_q.speed_setpoint; // R03
      end else begin
        st_d.upd_cnt = st_q.upd_cnt + 18'd1;
      end
    end
    // Desired pulses: reference scaled by target over span
    if (ref_tick && !open_lp) begin // R21 R22
      if ({1'b0, st_q.acc} + {2'b00, (st_q.target > span) ? span : st_q.target} >= {2'b00, span}) begin
        st_d.acc = 8'(st_q.acc + {1'b0, (st_q.target > span) ? span : st_q.target} - {1'b0, span});
        st_d.des = 1'b1;
      end else begin
        st_d.acc = 8'(st_q.acc + {1'b0, (st_q.target > span) ? span : st_q.target});
      end
    end
    // Up/down counter, saturating both ways
    if (!open_lp) begin
      if (st_q.des && !fb_tick && st_q.updn != 6'h3f) begin // R24
        st_d.updn = st_q.updn + 6'h01;
      end else if (fb_tick && !st_q.des && st_q.updn != 6'h00) begin
        st_d.updn = st_q.updn - 6'h01;
      end
    end
    // Tach period count, saturates so a stall stays failed
    if (fb_tick) begin // R13
      st_d.tach_period_count = st_q.pcnt;
      st_d.pcnt = '0; // R29
    end else if (osc_tick && st_q.pcnt != 8'hff) begin
      st_d.pcnt = st_q.pcnt + 8'h01; // R29
    end
    // Saturated counter stands in for the hidden overflow flag
    st_d.fan_fail = (st_q.tach_period_count > st_q.tach_period_limit) | (st_q.pcnt == 8'hff) | open_lp; // R14 R16 R27
    st_d.full_speed = ~open_lp & (st_q.updn == 6'h3f); // R15
    st_d.therm_open = therm_open_cfg | open_lp; // R09
    // Thermal shutdown with hysteresis
    // Between the two limits the previous state holds
    if (drv_temp > `FSLC_T_OFF_DEGC) begin // R10
      st_d.drv_off = 1'b1;
    end else if (drv_temp < `FSLC_T_ON_DEGC) begin
      st_d.drv_off = 1'b0;
    end
    st_d.drv_en = ~st_d.drv_off;
    if (st_d.drv_off) begin
      st_d.drive = 7'h00;
    end else if (open_lp) begin
      st_d.drive = (st_q.target >= `FSLC_DRIVE_FULL) ? `FSLC_DRIVE_FULL : st_q.target; // R07
    end else begin
      st_d.drive = {1'b0, st_q.updn}; // R06 R24
    end
    st_d.adc.rcancel_en = st_q.mode[7]; // R17
    st_d.adc.gain_up    = st_q.mode[5]; // R19
    st_d.adc.gain_step  = st_q.mode[4:2];
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      // Register defaults; loop state starts at zero
      st_q                       <= '0;
      st_q.tach_prescale_divisor <= `FSLC_RST_PRESC;
      st_q.tach_period_limit     <= `FSLC_RST_PLIM;
      st_q.loop_update_rate      <= `FSLC_RST_RATE; // R05
      st_q.mode                  <= `FSLC_RST_MODE;
      st_q.loop_gain_cfg         <= `FSLC_RST_GAIN;
      st_q.ref_fullscale_divider <= `FSLC_RST_FSCALE;
      st_q.speed_setpoint        <= `FSLC_RST_SETPOINT;
    end else begin
      st_q <= st_d;
    end
  end

  assign rdata      = st_q.rdata;
  assign rvalid     = st_q.rvalid;
  assign fan_drive  = st_q.drive;
  assign fan_drv_en = st_q.drv_en;
  assign fan_fail   = st_q.fan_fail;
  assign full_speed = st_q.full_speed;
  assign therm_open = st_q.therm_open;
  assign adc_cfg    = st_q.adc;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_FSCALE_CLAMP: assert property (fullscale_eff >= 8'h7f) // R25
    else $error("full-scale divider below 127");
  AST_OPEN_FAIL: assert property (open_lp |=> fan_fail) // R27
    else $error("fail bit not held in open loop");
  AST_OPEN_THERM: assert property (open_lp |=> therm_open) // R09
    else $error("thermal open not forced");
  AST_DRV_HOT: assert property (drv_temp > 8'd150 |=> !fan_drv_en && fan_drive == 7'h00) // R10
    else $error("driver not shut down when hot");
  AST_DRV_HYST: assert property (st_q.drv_off && drv_temp >= 8'd140 |=> st_q.drv_off) // R10
    else $error("driver re-enabled above 140");
  AST_OPEN_DRIVE: assert property (open_lp && !st_d.drv_off && st_q.target < 7'h40
    |=> fan_drive == $past(st_q.target)) // R07
    else $error("open-loop drive differs from setpoint");
  AST_PERIOD_LOAD: assert property (fb_tick |=> st_q.tach_period_count == $past(st_q.pcnt) && st_q.pcnt == 8'h00) // R13
    else $error("period count not loaded");
  AST_FAIL_CMP: assert property (st_q.tach_period_count > st_q.tach_period_limit |=> fan_fail) // R14
    else $error("fail not set over limit");
  AST_OVF_FAIL: assert property (st_q.pcnt == 8'hff |=> fan_fail) // R16
    else $error("overflow not in fail bit");
  AST_NO_TACH: assert property (open_lp |-> !fb_raw) // R08
    else $error("feedback used in open loop");
  AST_FULL: assert property (!open_lp && st_q.updn == 6'h3f |=> full_speed) // R15
    else $error("full-speed flag missing");
  // Frozen updates must leave the active target alone
  AST_UPD_HOLD: assert property (run_stop |=> st_q.target == $past(st_q.target)) // R03
    else $error("target changed while stopped");
  AST_CLOSED_DRIVE: assert property (!open_lp && !st_d.drv_off |=> fan_drive == {1'b0, $past(st_q.updn)}) // R24
    else $error("closed-loop drive differs from counter");
  AST_ADC_MAP: assert property (1'b1 |=> adc_cfg == {$past(st_q.mode[7]), $past(st_q.mode[5:2])}) // R19
    else $error("gain bits not passed on");
  AST_RD_ANSWER: assert property (req.rd |=> rvalid)
    else $error("read not answered");
  AST_RD_PULSE: assert property (!req.rd |=> !rvalid)
    else $error("answer without read");

  COV_CLOSED_UP: cover property (!open_lp && st_q.des ##1 st_q.updn != 6'h00);
  COV_TACH_LOAD: cover property (fb_tick && st_q.pcnt > 8'h00);
  COV_SHUTDOWN: cover property (st_q.drv_off ##1 !st_q.drv_off);
  COV_OPEN_FULL: cover property (open_lp && fan_drive == 7'h40);
  COV_CSENSE_LOAD: cover property (st_q.loop_gain_cfg[`FSLC_GAIN_CSENSE] && fb_tick);
endmodule

// File: hdl/fslc_defs.svh
// Constants of the fan speed loop control block
`ifndef FSLC_DEFS_SVH
`define FSLC_DEFS_SVH
// Register command codes, read and write
`define FSLC_RD_SETPOINT 8'h15
`define FSLC_WR_SETPOINT 8'h1a
`define FSLC_RD_GAIN     8'h16
`define FSLC_WR_GAIN     8'h1b
`define FSLC_RD_PLIM     8'h18
`define FSLC_WR_PLIM     8'h1c
`define FSLC_RD_PCOUNT   8'h19
`define FSLC_RD_PRESC    8'h1d
`define FSLC_WR_PRESC    8'h1e
`define FSLC_RD_FSCALE   8'h1f
`define FSLC_WR_FSCALE   8'h20
`define FSLC_RD_RATE     8'h30
`define FSLC_WR_RATE     8'h31
`define FSLC_RD_MODE     8'h32
`define FSLC_WR_MODE     8'h33
`define FSLC_RD_STATUS   8'h02
// Reset values
`define FSLC_RST_PLIM    8'hff
`define FSLC_RST_PRESC   8'h01
`define FSLC_RST_RATE    8'h02
`define FSLC_RST_MODE    8'h00
`define FSLC_RST_GAIN    8'h80
`define FSLC_RST_FSCALE  8'hff
`define FSLC_RST_SETPOINT 7'h00
// Field positions and limits
`define FSLC_GAIN_OPEN   0
`define FSLC_GAIN_CSENSE 1
`define FSLC_FSCALE_MIN  8'h7f
`define FSLC_DRIVE_FULL 7'h40
// Temperatures in whole degrees
`define FSLC_T_OFF_DEGC 8'd150
`define FSLC_T_ON_DEGC  8'd140
// Timing: clock and on-chip oscillator in Hz
`define FSLC_CLK_HZ     200000000
`define FSLC_OSC_HZ     8415
`define FSLC_OSC_CYC    (`FSLC_CLK_HZ / `FSLC_OSC_HZ)
// Oscillator ticks in the 16 s slowest update interval
`define FSLC_UPD_SLOW   18'd134640
`endif

// File: hdl/fslc_pkg.sv
// Types of the fan speed loop control block
package fslc_pkg;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] cmd;
    logic [7:0] wdata;
  } fslc_req_type;

  typedef struct packed {
    logic       rcancel_en;
    logic       gain_up;
    logic [2:0] gain_step;
  } fslc_adc_type;

  typedef struct packed {
    logic [7:0]  tach_prescale_divisor;
    logic [7:0]  tach_period_limit;
    logic [7:0]  loop_update_rate;
    logic [7:0]  mode;
    logic [7:0]  loop_gain_cfg;
    logic [7:0]  ref_fullscale_divider;
    logic [6:0]  speed_setpoint;
    logic [6:0]  target;
    logic [7:0]  tach_period_count;
    logic [7:0]  pcnt;
    logic [5:0]  updn;
    logic [7:0]  acc;
    logic        des;
    logic [17:0] upd_cnt;
    logic        drv_off;
    logic [6:0]  drive;
    logic        drv_en;
    logic        fan_fail;
    logic        full_speed;
    logic        therm_open;
    fslc_adc_type adc;
    logic [7:0]  rdata;
    logic        rvalid;
  } fslc_state_type;
endpackage

// File: hdl/fslc_edge_sync.sv
// Two-stage synchroniser with rising-edge pulse
`timescale 1ns/100ps
module fslc_edge_sync import fslc_pkg::*; (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Pin and pulse
  input  wire logic pin,
  output logic      rise
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic rise;
  } fslc_sync_type;

  fslc_sync_type st_q;
  fslc_sync_type st_d;

  always_comb begin
    st_d      = st_q;
    st_d.s1   = pin;
    st_d.s2   = st_q.s1;
    st_d.s3   = st_q.s2;
    st_d.rise = st_q.s2 & ~st_q.s3;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign rise = st_q.rise;
endmodule

// File: hdl/fslc_pulse_div.sv
// Pulse divider: one output pulse per div input pulses
`timescale 1ns/100ps
module fslc_pulse_div import fslc_pkg::*; #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Pulses and ratio
  input  wire logic         in_pulse,
  input  wire logic [W-1:0] div,
  output logic              out_pulse
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic         out;
  } fslc_div_type;

  fslc_div_type st_q;
  fslc_div_type st_d;

  always_comb begin
    st_d     = st_q;
    st_d.out = 1'b0;
    if (in_pulse) begin
      // Ratio of zero behaves as one
      if (st_q.cnt + W'(1) >= div) begin
        st_d.cnt = '0;
        st_d.out = 1'b1;
      end else begin
        st_d.cnt = st_q.cnt + W'(1);
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign out_pulse = st_q.out;
endmodule

// File: verif/fslc_fan_model.sv
// Fan model: tachometer or commutation pulses at a set period
`timescale 1ns/100ps
module fslc_fan_model (
  // Clock
  input  wire logic        clk,
  // Period in clocks, 0 = stalled; feedback choice
  input  wire logic [15:0] period,
  input  wire logic        csense,
  // Fan pins
  output logic             tach_in,
  output logic             cur_step_in
);
  logic [15:0] cnt_q;
  logic        ph_q;
  initial begin
    cnt_q = 16'h0;
    ph_q = 1'b0;
  end
  always @(posedge clk) begin
    cnt_q <= (cnt_q + 16'h1 >= period) ? 16'h0 : cnt_q + 16'h1;
    ph_q  <= (period != 16'h0) && (cnt_q < period / 2);
  end
  // Unused or stalled tach line rests at its pull-up
  assign tach_in     = csense | (period == 16'h0) | ph_q;
  assign cur_step_in = csense & ph_q;
endmodule

// File: verif/fslc_top_test.sv
// Self-checking bench of the fan speed loop control block
`timescale 1ns/100ps
`include "fslc_defs.svh"
module fslc_top_test import fslc_pkg::*; ;
  logic         clk = 1'b0;
  logic         rst = 1'b1;
  fslc_req_type req = '0;
  logic [7:0]   rdata;
  logic         rvalid;
  logic         tach_in;
  logic         cur_step_in;
  logic [7:0]   drv_temp = 8'd25;
  logic         run_stop = 1'b0;
  logic         therm_open_cfg = 1'b0;
  logic [6:0]   fan_drive;
  logic         fan_drv_en;
  logic         fan_fail;
  logic         full_speed;
  logic         therm_open;
  fslc_adc_type adc_cfg;
  logic [15:0]  period = 16'd100;
  logic         csense = 1'b0;
  logic [7:0]   lo_q [$];
  logic [7:0]   hi_q [$];
  logic [7:0]   m;
  logic [7:0]   e;
  int           num_errors = 0;
  int           n_checks = 0;
  int           seed = 49481;

  always #2.5 clk = ~clk;

  // Short oscillator divide keeps the run brief
  fslc_top #(.OSC_DIV(4)) DUT (.clk(clk), .rst(rst), .req(req), .rdata(rdata), .rvalid(rvalid),
    .tach_in(tach_in), .cur_step_in(cur_step_in), .drv_temp(drv_temp), .run_stop(run_stop),
    .therm_open_cfg(therm_open_cfg), .fan_drive(fan_drive), .fan_drv_en(fan_drv_en),
    .fan_fail(fan_fail), .full_speed(full_speed), .therm_open(therm_open), .adc_cfg(adc_cfg));
  fslc_fan_model fan (.clk(clk), .period(period), .csense(csense), .tach_in(tach_in),
    .cur_step_in(cur_step_in));

  task automatic chk(input string nm, input logic [7:0] lo, input logic [7:0] hi, input logic [7:0] got);
    n_checks++;
    if (((got >= lo) && (got <= hi)) !== 1'b1) begin
      num_errors++;
      $display("Error %s expected %h..%h seen %h", nm, lo, hi, got);
    end
  endtask

  task automatic bit_chk(input string nm, input logic x, input logic got);
    chk(nm, {7'h0, x}, {7'h0, x}, {7'h0, got});
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] c, input logic [7:0] d);
    req <= '{1'b1, 1'b0, c, d};
    @(posedge clk);
    req <= '0;
    @(posedge clk);
  endtask

  // Expected range is queued; the monitor compares on rvalid
  task automatic rd(input logic [7:0] c, input logic [7:0] lo, input logic [7:0] hi);
    lo_q.push_back(lo);
    hi_q.push_back(hi);
    req <= '{1'b0, 1'b1, c, 8'h00};
    @(posedge clk);
    req <= '0;
    cyc(2);
  endtask

  task automatic drive_chk(input logic [6:0] v, input int n);
    for (int k = 0; k < n && fan_drive !== v; k++) @(posedge clk);
    chk("fan_drive", {1'b0, v}, {1'b0, v}, {1'b0, fan_drive});
  endtask

  always @(posedge clk) begin
    if (rvalid === 1'b1) begin
      if (lo_q.size() == 0) begin
        num_errors++;
        $display("Error rdata expected none seen %h", rdata);
      end else
        chk("rdata", lo_q.pop_front(), hi_q.pop_front(), rdata);
    end
  end

  task automatic stop_test;
    $display("Checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    #450000;
    num_errors++;
    stop_test();
  end

  initial begin
    logic [7:0] rc [7];
    logic [7:0] rv [7];
    logic [7:0] tv [4];
    logic [3:0] te;
    rc = '{`FSLC_RD_PRESC, `FSLC_RD_PLIM, `FSLC_RD_RATE, `FSLC_RD_FSCALE, `FSLC_RD_SETPOINT, `FSLC_RD_MODE,
           `FSLC_RD_GAIN};
    rv = '{8'h01, 8'hff, 8'h02, 8'hff, 8'h00, 8'h00, 8'h80};
    tv = '{8'd150, 8'd151, 8'd140, 8'd139};
    te = 4'b1001;
    cyc(6);
    rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 7; i++) rd(rc[i], rv[i], rv[i]);
    rd(8'h7e, 8'h00, 8'h00);
    repeat (4) begin
      m = 8'($random(seed));
      e = {3'h0, m[7], m[5], m[4:2]};
      wr(`FSLC_WR_MODE, m);
      cyc(2);
      chk("adc_cfg", e, e, {3'h0, adc_cfg});
      rd(`FSLC_RD_MODE, m & 8'hbc, m & 8'hbc);
    end
    for (int i = 0; i < 4; i++) begin
      drv_temp <= tv[i];
      cyc(4);
      bit_chk("fan_drv_en", te[i], fan_drv_en);
    end
    // 100 clocks per pulse is 25 oscillator ticks
    for (int d = 0; d < 4; d++) begin
      wr(`FSLC_WR_PRESC, 8'(d));
      cyc(600 << d);
      rd(`FSLC_RD_PCOUNT, 8'(25 * (1 << d) - 2), 8'(25 * (1 << d) + 2));
    end
    wr(`FSLC_WR_PRESC, 8'h00);
    wr(`FSLC_WR_PLIM, 8'h20);
    cyc(400);
    bit_chk("fan_fail", 1'b0, fan_fail);
    bit_chk("therm_open", 1'b0, therm_open);
    wr(`FSLC_WR_PLIM, 8'h14);
    cyc(400);
    bit_chk("fan_fail", 1'b1, fan_fail);
    wr(`FSLC_WR_PLIM, 8'hff);
    period <= 16'd0;
    cyc(1500);
    bit_chk("fan_fail", 1'b1, fan_fail);
    rd(`FSLC_RD_STATUS, 8'h01, 8'h01);
    period <= 16'd100;
    cyc(500);
    bit_chk("fan_fail", 1'b0, fan_fail);
    // Tach line held high: only current steps can load the count
    csense <= 1'b1;
    wr(`FSLC_WR_GAIN, 8'h82);
    wr(`FSLC_WR_PRESC, 8'h01);
    cyc(1200);
    rd(`FSLC_RD_PCOUNT, 8'd48, 8'd52);
    csense <= 1'b0;
    period <= 16'd0;
    wr(`FSLC_WR_FSCALE, 8'h10);
    wr(`FSLC_WR_RATE, 8'hff);
    wr(`FSLC_WR_GAIN, 8'hc0);
    wr(`FSLC_WR_SETPOINT, 8'h3f);
    cyc(20000);
    bit_chk("full_speed", 1'b0, full_speed);
    for (int k = 0; k < 25000 && full_speed !== 1'b1; k++) @(posedge clk);
    bit_chk("full_speed", 1'b1, full_speed);
    drive_chk(7'h3f, 0);
    period <= 16'd100;
    wr(`FSLC_WR_GAIN, 8'h81);
    cyc(600);
    bit_chk("fan_fail", 1'b1, fan_fail);
    bit_chk("therm_open", 1'b1, therm_open);
    bit_chk("full_speed", 1'b0, full_speed);
    wr(`FSLC_WR_SETPOINT, 8'h40);
    drive_chk(7'h40, 5000);
    run_stop <= 1'b1;
    wr(`FSLC_WR_SETPOINT, 8'h20);
    cyc(5000);
    drive_chk(7'h40, 0);
    run_stop <= 1'b0;
    drive_chk(7'h20, 5000);
    stop_test();
  end
endmodule
